// ### include/lpt_pkg.sv
package lpt_pkg;
    // register byte addresses (each register in the low byte of its own word)
    localparam logic [16:0] OFS_MODE2      = 17'h1ffe3; // power save field
    localparam logic [16:0] OFS_HWIDTH     = 17'h1ffe4;
    localparam logic [16:0] OFS_VHEIGHT_LO = 17'h1ffe5;
    localparam logic [16:0] OFS_VHEIGHT_HI = 17'h1ffe6;
    localparam logic [16:0] OFS_LSYNC_POS  = 17'h1ffe7;
    localparam logic [16:0] OFS_HBLANK     = 17'h1ffe8;
    localparam logic [16:0] OFS_FSYNC_POS  = 17'h1ffe9;
    localparam logic [16:0] OFS_VBLANK     = 17'h1ffea;
    localparam logic [16:0] OFS_PANEL_MODE = 17'h1ffe1;

    // byte address inside the aperture: printed offsets times four
    localparam int          ADDR_W         = 19;

    // field positions
    localparam int          PANEL_TFT_BIT  = 7;
    localparam int          VBLANK_STS_BIT = 7;

    // power save codes
    localparam logic [1:0]  PS_SAVE        = 2'h0;
    localparam logic [1:0]  PS_NORMAL      = 2'h3;

    // horizontal arithmetic
    localparam logic [6:0]  HWIDTH_MIN     = 7'h03;
    localparam int          CELL_PIX       = 8;
    localparam logic [5:0]  LSYNC_ADD      = 6'h02;
    localparam logic [5:0]  HBLANK_ADD     = 6'h04;

    // reset values
    localparam logic [1:0]  RST_PS         = 2'h0;
    localparam logic [6:0]  RST_HWIDTH     = 7'h03;
    localparam logic [9:0]  RST_VHEIGHT    = 10'h000;
    localparam logic [4:0]  RST_LSYNC      = 5'h00;
    localparam logic [4:0]  RST_HBLANK     = 5'h00;
    localparam logic [5:0]  RST_FSYNC      = 6'h01;
    localparam logic [5:0]  RST_VBLANK     = 6'h01;
    localparam logic        RST_TFT        = 1'b0;

    // pulse widths: one cell for line sync, one line for frame sync
    localparam logic [2:0]  LSYNC_WIDTH    = 3'h7;

    // power mode
    typedef enum logic [1:0] {
        LPT_PS_SAVE,
        LPT_PS_NORMAL,
        LPT_PS_RESERVED
    } lpt_ps_t;
endpackage

// ### hdl/lpt_timing.sv
`timescale 1ns/10ps
module lpt_timing (
    input  wire logic        clock,              // pixel clock, 125 MHz
    input  wire logic        reset_n,            // synchronous, active low
    input  wire logic [18:0] avs_address,        // byte address
    input  wire logic        avs_read,           // read strobe
    input  wire logic        avs_write,          // write strobe
    input  wire logic [31:0] avs_writedata,      // write data
    input  wire logic [3:0]  avs_byteenable,     // byte lanes
    output logic      [31:0] avs_readdata,       // read data
    output logic             avs_waitrequest,    // stall
    output logic             line_sync_pulse,    // line sync to panel
    output logic             frame_sync_pulse,   // frame sync to panel
    output logic             display_enable,     // pixel data valid
    output logic             power_save,         // software power save active
    output logic             tft_mode            // panel type is tft
);

    // configuration state
    logic [1:0]  ps_reg;
    logic [6:0]  hwidth_reg;
    logic [9:0]  vheight_reg;
    logic [4:0]  lsync_reg;
    logic [4:0]  hblank_reg;
    logic [5:0]  fsync_reg;
    logic [5:0]  vblank_reg;
    logic        tft_reg;
    logic        ack_reg;
    logic [31:0] rdata_reg;

    // raster state
    logic [10:0] hcnt_reg;
    logic [10:0] hcnt_next;
    logic [10:0] vcnt_reg;
    logic [10:0] vcnt_next;
    logic        lsync_reg_q;
    logic        fsync_reg_q;
    logic        de_reg;
    logic [2:0]  lwid_reg;
    logic [10:0] fsync_line_reg;

    lpt_pkg::lpt_ps_t ps_mode;

    // cell count times eight, as pixels
    function automatic logic [10:0] cells_to_pix(input logic [7:0] cells);
        cells_to_pix = {cells, 3'h0};
    endfunction

    // address match against a printed register byte address
    function automatic logic hit(input logic [18:0] a, input logic [16:0] ofs);
        hit = (a[18:2] == ofs);
    endfunction

    // power save decode
    always_comb begin
        unique case (ps_reg)
            lpt_pkg::PS_SAVE:   ps_mode = lpt_pkg::LPT_PS_SAVE;
            lpt_pkg::PS_NORMAL: ps_mode = lpt_pkg::LPT_PS_NORMAL;
            default:            ps_mode = lpt_pkg::LPT_PS_RESERVED;
        endcase
    end

    // reserved codes are treated as power save: safer than driving an unknown mode
    wire         run_en     = (ps_mode == lpt_pkg::LPT_PS_NORMAL);

    // geometry in pixels and lines
    wire  [10:0] h_active   = cells_to_pix({1'b0, hwidth_reg} + 8'h01);
    wire  [10:0] h_blank    = cells_to_pix({2'h0, {1'b0, hblank_reg} + lpt_pkg::HBLANK_ADD});
    wire  [10:0] h_total    = h_active + h_blank;
    wire  [10:0] v_active   = {1'b0, vheight_reg} + 11'h001;
    wire  [10:0] v_total    = v_active + {5'h00, vblank_reg};
    wire  [10:0] lsync_ofs  = cells_to_pix({2'h0, {1'b0, lsync_reg} + lpt_pkg::LSYNC_ADD});
    // passive panels take line sync at the start of blank, position ignored
    wire  [10:0] lsync_at   = tft_reg ? (h_active + lsync_ofs) : h_active;
    // tft frame sync from programmed lines, passive at first blank line;
    // a setting of one lands on the first blank line so the largest legal value still fits
    wire  [10:0] fsync_at   = tft_reg ? (v_active + {5'h00, fsync_reg} - 11'h001)
                                      : v_active;
    wire         h_last     = (hcnt_reg >= h_total - 11'h001);
    wire         v_last     = (vcnt_reg >= v_total - 11'h001);
    wire         in_vblank  = (vcnt_reg >= v_active);

    // bus decode
    wire         sel_mode2  = hit(avs_address, lpt_pkg::OFS_MODE2);
    wire         sel_pmode  = hit(avs_address, lpt_pkg::OFS_PANEL_MODE);
    wire         sel_hw     = hit(avs_address, lpt_pkg::OFS_HWIDTH);
    wire         sel_vlo    = hit(avs_address, lpt_pkg::OFS_VHEIGHT_LO);
    wire         sel_vhi    = hit(avs_address, lpt_pkg::OFS_VHEIGHT_HI);
    wire         sel_ls     = hit(avs_address, lpt_pkg::OFS_LSYNC_POS);
    wire         sel_hb     = hit(avs_address, lpt_pkg::OFS_HBLANK);
    wire         sel_fs     = hit(avs_address, lpt_pkg::OFS_FSYNC_POS);
    wire         sel_vb     = hit(avs_address, lpt_pkg::OFS_VBLANK);
    // writes land on the answering edge, when the master sees waitrequest low
    wire         wr_go      = avs_write & ack_reg & avs_byteenable[0];
    wire  [7:0]  wd         = avs_writedata[7:0];

    // read mux, unmapped reads return zero
    logic [7:0] rd_byte;
    always_comb begin
        rd_byte = 8'h00;
        if (sel_mode2) rd_byte = {6'h00, ps_reg};
        if (sel_pmode) rd_byte = {tft_reg, 7'h00};
        if (sel_hw)    rd_byte = {1'b0, hwidth_reg};
        if (sel_vlo)   rd_byte = vheight_reg[7:0];
        if (sel_vhi)   rd_byte = {6'h00, vheight_reg[9:8]};
        if (sel_ls)    rd_byte = {3'h0, lsync_reg};
        if (sel_hb)    rd_byte = {3'h0, hblank_reg};
        if (sel_fs)    rd_byte = {2'h0, fsync_reg};
        if (sel_vb)    rd_byte = {in_vblank, 1'b0, vblank_reg};
    end

    // one wait cycle per access, answer on the second edge
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
    assign avs_readdata    = rdata_reg;

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= (avs_read | avs_write) & ~ack_reg;
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    // register writes, low byte lane only
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            ps_reg      <= lpt_pkg::RST_PS;
            tft_reg     <= lpt_pkg::RST_TFT;
            hwidth_reg  <= lpt_pkg::RST_HWIDTH;
            vheight_reg <= lpt_pkg::RST_VHEIGHT;
            lsync_reg   <= lpt_pkg::RST_LSYNC;
            hblank_reg  <= lpt_pkg::RST_HBLANK;
            fsync_reg   <= lpt_pkg::RST_FSYNC;
            vblank_reg  <= lpt_pkg::RST_VBLANK;
        end else if (wr_go) begin
            if (sel_mode2) ps_reg           <= wd[1:0];
            if (sel_pmode) tft_reg          <= wd[lpt_pkg::PANEL_TFT_BIT];
            if (sel_hw)    hwidth_reg       <= wd[6:0];
            if (sel_vlo)   vheight_reg[7:0] <= wd;
            if (sel_vhi)   vheight_reg[9:8] <= wd[1:0];
            if (sel_ls)    lsync_reg        <= wd[4:0];
            if (sel_hb)    hblank_reg       <= wd[4:0];
            if (sel_fs)    fsync_reg        <= wd[5:0];
            if (sel_vb)    vblank_reg       <= wd[5:0];
        end
    end

    // raster counters; held at origin in power save
    always_comb begin
        hcnt_next = h_last ? 11'h000 : hcnt_reg + 11'h001;
        vcnt_next = vcnt_reg;
        if (h_last) begin
            vcnt_next = v_last ? 11'h000 : vcnt_reg + 11'h001;
        end
        if (!run_en) begin
            hcnt_next = 11'h000;
            vcnt_next = 11'h000;
        end
    end

    always_ff @(posedge clock) begin
        if (!reset_n) begin
            hcnt_reg <= 11'h000;
            vcnt_reg <= 11'h000;
        end else begin
            hcnt_reg <= hcnt_next;
            vcnt_reg <= vcnt_next;
        end
    end

    // line sync: one cell wide, starting at the computed position
    wire ls_start = run_en & (hcnt_reg == lsync_at);
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            lsync_reg_q <= 1'b0;
            lwid_reg    <= 3'h0;
        end else if (ls_start) begin
            lsync_reg_q <= 1'b1;
            lwid_reg    <= lpt_pkg::LSYNC_WIDTH;
        end else if (lwid_reg != 3'h0) begin
            lwid_reg    <= lwid_reg - 3'h1;
        end else begin
            lsync_reg_q <= 1'b0;
        end
    end

    // frame sync: high for the whole chosen blank line, rising with its line sync
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            fsync_reg_q    <= 1'b0;
            fsync_line_reg <= 11'h000;
        end else begin
            fsync_line_reg <= fsync_at;
            if (ls_start) begin
                fsync_reg_q <= (vcnt_reg == fsync_line_reg);
            end else if (!run_en) begin
                fsync_reg_q <= 1'b0;
            end
        end
    end

    // data enable during active pixels of active lines
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            de_reg <= 1'b0;
        end else begin
            de_reg <= run_en & (hcnt_next < h_active) & (vcnt_next < v_active);
        end
    end

    assign line_sync_pulse  = lsync_reg_q;
    assign frame_sync_pulse = fsync_reg_q;
    assign display_enable   = de_reg;
    assign power_save       = ~run_en;
    assign tft_mode         = tft_reg;

endmodule

// ### tb/lpt_timing_properties.sv
`timescale 1ns/10ps
module lpt_timing_properties (
    input wire logic        clock,            // pixel clock
    input wire logic        reset_n,          // sync reset
    input wire logic [18:0] avs_address,      // byte address
    input wire logic        avs_read,         // read strobe
    input wire logic        avs_write,        // write strobe
    input wire logic [31:0] avs_writedata,    // write data
    input wire logic [3:0]  avs_byteenable,   // byte lanes
    input wire logic [31:0] avs_readdata,     // read data
    input wire logic        avs_waitrequest,  // stall
    input wire logic        line_sync_pulse,  // line sync
    input wire logic        frame_sync_pulse, // frame sync
    input wire logic        power_save,       // save mode
    input wire logic        tft_mode          // panel type
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    // completed low-lane writes to the mode registers
    wire req      = avs_read | avs_write;
    wire done_wr  = avs_write & ~avs_waitrequest & avs_byteenable[0];
    wire mode_wr  = done_wr & (avs_address == {lpt_pkg::OFS_MODE2, 2'b00});
    wire panel_wr = done_wr & (avs_address == {lpt_pkg::OFS_PANEL_MODE, 2'b00});

    a_one_wait: assert property (req && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held past one cycle");
    a_single_ack: assert property (req && !avs_waitrequest |=> !req || avs_waitrequest)
        else $error("request acknowledged twice");
    a_read_upper_zero: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bits not zero");
    a_power_decode: assert property (
        mode_wr |=> power_save == ($past(avs_writedata[1:0]) != 2'h3))
        else $error("power save decode wrong");
    a_tft_select: assert property (
        panel_wr |=> tft_mode == $past(avs_writedata[lpt_pkg::PANEL_TFT_BIT]))
        else $error("panel type not taken");
    // panel outputs are only judged while running, a save entry may cut a pulse
    a_line_sync_width: assert property (disable iff (!reset_n || power_save)
        $rose(line_sync_pulse) |-> line_sync_pulse[*8] ##1 !line_sync_pulse)
        else $error("line sync width wrong");
    a_frame_on_line: assert property (disable iff (!reset_n || power_save)
        $rose(frame_sync_pulse) |-> $rose(line_sync_pulse))
        else $error("frame sync not aligned to line sync");
    a_frame_until_line: assert property (disable iff (!reset_n || power_save)
        $fell(frame_sync_pulse) |-> $rose(line_sync_pulse))
        else $error("frame sync ended off a line sync");
endmodule
bind lpt_timing lpt_timing_properties chk_u (.clock(clock), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .line_sync_pulse(line_sync_pulse), .frame_sync_pulse(frame_sync_pulse),
    .power_save(power_save), .tft_mode(tft_mode));

// ### tb/lpt_panel_model.sv
`timescale 1ns/10ps
module lpt_panel_model (
    input  wire logic clock,            // pixel clock
    input  wire logic line_sync_pulse,  // line sync
    input  wire logic frame_sync_pulse, // frame sync
    input  wire logic display_enable,   // pixel data valid
    output int        line_len,         // clocks between line syncs
    output int        act_len,          // active pixels in a line
    output int        ls_gap,           // data end to line sync
    output int        fs_lines,         // lines from data end to frame sync
    output int        frame_lines       // lines between frame syncs
);
    int   t, ls_t, de_t, run, nl, nf;
    logic ls_q, fs_q, de_q;
    // panel side measures what it sees; registered outputs read pre-edge
    always @(posedge clock) begin
        t++;
        if (display_enable && !de_q) run = 0;
        if (display_enable) run++;
        if (!display_enable && de_q) begin
            act_len = run;
            de_t = t;
            nl = 0;
        end
        if (line_sync_pulse && !ls_q) begin
            line_len = t - ls_t;
            ls_t = t;
            ls_gap = t - de_t;
            nl++;
            nf++;
        end
        if (frame_sync_pulse && !fs_q) begin
            fs_lines = nl;
            frame_lines = nf;
            nf = 0;
        end
        ls_q = line_sync_pulse;
        fs_q = frame_sync_pulse;
        de_q = display_enable;
    end
endmodule

// ### tb/tb_lpt_timing.sv
`timescale 1ns/10ps
module tb_lpt_timing;
    logic        clock, reset_n, avs_read, avs_write, avs_waitrequest;
    logic        lsp, fsp, de, ps, tft;
    logic [18:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0]  avs_byteenable;
    logic [7:0]  rd;
    int          bad_count, checks, line_len, act_len, ls_gap, fs_lines, frame_lines, d0, f0;

    lpt_timing dut_u (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .line_sync_pulse(lsp), .frame_sync_pulse(fsp),
        .display_enable(de), .power_save(ps), .tft_mode(tft));
    lpt_panel_model panel_u (.clock(clock), .line_sync_pulse(lsp), .frame_sync_pulse(fsp),
        .display_enable(de), .line_len(line_len), .act_len(act_len), .ls_gap(ls_gap),
        .fs_lines(fs_lines), .frame_lines(frame_lines));

    // 125 MHz pixel clock
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic conclude;
        $display("checks %0d errors %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one bus cycle, held until waitrequest is seen low; an edge passes after release
    task automatic access(input logic wr, input logic [16:0] ofs, input logic [7:0] wd,
                          input logic [3:0] be);
        int n;
        avs_address <= {ofs, 2'b00};
        avs_writedata <= {24'h0, wd};
        avs_byteenable <= be;
        avs_read <= !wr;
        avs_write <= wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata[7:0];
        if (n >= 50) begin
            bad_count++;
            conclude();
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [16:0] ofs, input logic [7:0] d);
        access(1'b1, ofs, d, 4'h1);
    endtask

    task automatic rdc(input logic [16:0] ofs, input logic [7:0] exp, input logic [7:0] m);
        access(1'b0, ofs, 8'h00, 4'hf);
        check(rd & m, exp, "register read");
    endtask

    // restart the panel with one field changed, then let two frames pass
    task automatic rerun(input logic [16:0] ofs, input logic [7:0] d);
        wr(lpt_pkg::OFS_MODE2, 8'h00);
        wr(ofs, d);
        wr(lpt_pkg::OFS_MODE2, 8'h03);
        repeat (1000) @(posedge clock);
    endtask

    initial begin
        reset_n = 1'b0;
        {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
        repeat (20) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rdc(lpt_pkg::OFS_HWIDTH, 8'h03, 8'h7f);
        rdc(lpt_pkg::OFS_FSYNC_POS, 8'h01, 8'h3f);
        rdc(17'h1fff0, 8'h00, 8'hff);
        check(ps, 1'b1, "power save");
        for (int c = 0; c < 4; c++) begin
            wr(lpt_pkg::OFS_MODE2, 8'(c));
            check(ps, c != 3, "power save");
        end
        wr(lpt_pkg::OFS_MODE2, 8'h00);
        access(1'b1, lpt_pkg::OFS_HWIDTH, 8'h55, 4'h0);
        rdc(lpt_pkg::OFS_HWIDTH, 8'h03, 8'h7f);
        wr(lpt_pkg::OFS_HWIDTH, 8'h7f);
        rdc(lpt_pkg::OFS_HWIDTH, 8'h7f, 8'h7f);
        wr(lpt_pkg::OFS_VHEIGHT_LO, 8'hff);
        wr(lpt_pkg::OFS_VHEIGHT_HI, 8'hff);
        rdc(lpt_pkg::OFS_VHEIGHT_LO, 8'hff, 8'hff);
        rdc(lpt_pkg::OFS_VHEIGHT_HI, 8'h03, 8'h03);
        // small panel: 32 pixels by 4 lines, kept within host limits
        wr(lpt_pkg::OFS_HWIDTH, 8'h03);
        wr(lpt_pkg::OFS_VHEIGHT_LO, 8'h03);
        wr(lpt_pkg::OFS_VHEIGHT_HI, 8'h00);
        wr(lpt_pkg::OFS_HBLANK, 8'h01);
        wr(lpt_pkg::OFS_VBLANK, 8'h02);
        wr(lpt_pkg::OFS_LSYNC_POS, 8'h01);
        rerun(lpt_pkg::OFS_PANEL_MODE, 8'h00);
        check(line_len, 32'd72, "line length");
        check(act_len, 32'd32, "active width");
        check(frame_lines, 32'd6, "frame lines");
        d0 = ls_gap;
        f0 = fs_lines;
        rerun(lpt_pkg::OFS_PANEL_MODE, 8'h80);
        check(tft, 1'b1, "panel type");
        check(ls_gap, d0 + 24, "line sync delay");
        check(fs_lines, f0, "frame sync lines");
        check(line_len, 32'd72, "line length");
        rerun(lpt_pkg::OFS_FSYNC_POS, 8'h02);
        check(fs_lines, f0 + 1, "frame sync lines");
        conclude();
    end
endmodule
